// ---- hw/asc_params.svh ----
`ifndef ASC_PARAMS_SVH
`define ASC_PARAMS_SVH
// ==========================================
// Register byte addresses
`define ASC_OFF_CTRL 8'h00
`define ASC_OFF_SEL0 8'h04
`define ASC_OFF_SEL1 8'h08
`define ASC_OFF_SELB 8'h0c
`define ASC_OFF_TRS 8'h10
`define ASC_OFF_CMPC 8'h14
`define ASC_OFF_CMPS 8'h18
`define ASC_OFF_CMPL 8'h1c
`define ASC_OFF_REF0 8'h20
`define ASC_OFF_REF1 8'h24
`define ASC_OFF_STAT 8'h28
`define ASC_OFF_MASK 8'h2c
`define ASC_OFF_RES 8'h40
// ==========================================
// Field positions
`define ASC_CTL_ST 0
`define ASC_CTL_MODE 1
`define ASC_CTL_LP 3
`define ASC_CTL_TRIGEN 4
`define ASC_CTL_EXT 5
`define ASC_CTL_AUTOCLR 8
`define ASC_CTL_BUSY 9
`define ASC_CMP_WIN 0
`define ASC_CMP_AE 1
`define ASC_CMP_AIE 2
`define ASC_ST_END 0
`define ASC_ST_MATCH 1
`define ASC_ST_MISS 2
`define ASC_TRS_B 8
`define ASC_NCH 22
`define ASC_TRS_OFF 6'h3f
`define ASC_RESP_OK 2'b00
`define ASC_RESP_ERR 2'b10
// ==========================================
// Timing
`define ASC_CLK_NS 10
`define ASC_CONV_HS_NS 1000
`define ASC_CONV_LP_NS 2000
`define ASC_CONV_HS_CYC (`ASC_CONV_HS_NS / `ASC_CLK_NS)
`define ASC_CONV_LP_CYC (`ASC_CONV_LP_NS / `ASC_CLK_NS)
`endif

// ---- hw/asc_pkg.sv ----
package asc_pkg;
   typedef enum logic [1:0] {ASC_IDLE = 2'b00, ASC_PICK = 2'b01, ASC_CONV = 2'b10} asc_state_e;
   typedef enum logic [1:0] {ASC_SINGLE = 2'b00, ASC_GROUP = 2'b01, ASC_CONT = 2'b10} asc_mode_e;
   typedef logic [21:0] asc_chmask_t;
   typedef logic [11:0] asc_data_t;
endpackage

// ---- hw/asc_top.sv ----
`timescale 1ns/10ps
`include "asc_params.svh"
module asc_top
   import asc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [11:0] sar_result,
   input wire logic external_trigger_pin,
   input wire logic link_event_conv_a,
   input wire logic link_event_conv_b,
   output logic [4:0] sar_chan,
   output logic sar_sample,
   output logic sar_low_power,
   output logic scan_busy,
   output logic compare_match_event,
   output logic compare_mismatch_event,
   output logic irq
);
   // ==========================================
   // Bus slave state
   logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic aw_full_reg, w_full_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg, rdata_reg;
   logic [3:0] w_strb_reg;
   logic [1:0] bresp_reg, rresp_reg;
   // ==========================================
   // Registers
   logic [9:0] ctrl_reg;
   logic [15:0] sel0_reg;
   logic [5:0] sel1_reg;
   asc_chmask_t selb_reg, cmps_reg, cmpl_reg;
   logic [13:0] trs_reg;
   logic [2:0] cmpc_reg, stat_reg, mask_reg;
   asc_data_t ref0_reg, ref1_reg;
   asc_data_t res_reg [`ASC_NCH];
   // ==========================================
   // Scan engine state
   asc_state_e state_reg;
   asc_chmask_t pend_reg;
   logic [7:0] cnt_reg;
   logic [4:0] chan_reg;
   logic grp_b_reg, sample_reg, match_reg, miss_reg, irq_reg;
   logic ext_s1_reg, ext_s2_reg, ext_s3_reg;

   // ==========================================
   // Write decode
   wire wr_en = aw_full_reg && w_full_reg && !bvalid_reg;
   wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   wire [31:0] wd = w_data_reg & wmask;
   wire wr_ctrl = wr_en && aw_addr_reg == `ASC_OFF_CTRL;
   wire wr_sel0 = wr_en && aw_addr_reg == `ASC_OFF_SEL0;
   wire wr_sel1 = wr_en && aw_addr_reg == `ASC_OFF_SEL1;
   wire wr_selb = wr_en && aw_addr_reg == `ASC_OFF_SELB;
   wire wr_trs = wr_en && aw_addr_reg == `ASC_OFF_TRS;
   wire wr_cmpc = wr_en && aw_addr_reg == `ASC_OFF_CMPC;
   wire wr_cmps = wr_en && aw_addr_reg == `ASC_OFF_CMPS;
   wire wr_cmpl = wr_en && aw_addr_reg == `ASC_OFF_CMPL;
   wire wr_ref0 = wr_en && aw_addr_reg == `ASC_OFF_REF0;
   wire wr_ref1 = wr_en && aw_addr_reg == `ASC_OFF_REF1;
   wire wr_stat = wr_en && aw_addr_reg == `ASC_OFF_STAT;
   wire wr_mask = wr_en && aw_addr_reg == `ASC_OFF_MASK;
   wire [7:0] wr_rel = aw_addr_reg - `ASC_OFF_RES;
   wire wr_res = wr_en && aw_addr_reg >= `ASC_OFF_RES && wr_rel[7:2] < 6'(`ASC_NCH);
   wire wr_ok = wr_ctrl || wr_sel0 || wr_sel1 || wr_selb || wr_trs || wr_cmpc || wr_cmps || wr_cmpl
      || wr_ref0 || wr_ref1 || wr_stat || wr_mask || wr_res;
   wire [31:0] ctrl_w = ({22'h0, ctrl_reg} & ~wmask) | wd;

   // ==========================================
   // Read decode
   wire ar_hs = s_axi_arvalid && arready_reg;
   wire [7:0] ra = s_axi_araddr;
   wire [7:0] rd_rel = ra - `ASC_OFF_RES;
   wire [4:0] rd_idx = rd_rel[6:2];
   wire rd_res = ra >= `ASC_OFF_RES && rd_rel[7:2] < 6'(`ASC_NCH);
   wire [31:0] rd_val =
      ra == `ASC_OFF_CTRL ? {22'h0, ctrl_reg} :
      ra == `ASC_OFF_SEL0 ? {16'h0, sel0_reg} :
      ra == `ASC_OFF_SEL1 ? {26'h0, sel1_reg} :
      ra == `ASC_OFF_SELB ? {10'h0, selb_reg} :
      ra == `ASC_OFF_TRS ? {18'h0, trs_reg} :
      ra == `ASC_OFF_CMPC ? {29'h0, cmpc_reg} :
      ra == `ASC_OFF_CMPS ? {10'h0, cmps_reg} :
      ra == `ASC_OFF_CMPL ? {10'h0, cmpl_reg} :
      ra == `ASC_OFF_REF0 ? {20'h0, ref0_reg} :
      ra == `ASC_OFF_REF1 ? {20'h0, ref1_reg} :
      ra == `ASC_OFF_STAT ? {29'h0, stat_reg} :
      ra == `ASC_OFF_MASK ? {29'h0, mask_reg} :
      rd_res ? {20'h0, res_reg[rd_idx]} : 32'h0;
   wire rd_ok = rd_res || ra <= `ASC_OFF_MASK && ra[1:0] == 2'h0;

   // ==========================================
   // AXI4-Lite handshakes, write answers one cycle after both halves held
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `ASC_RESP_OK;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0;
         w_strb_reg <= 4'h0;
      end
      else
      begin
         awready_reg <= !aw_full_reg && !(s_axi_awvalid && awready_reg);
         wready_reg <= !w_full_reg && !(s_axi_wvalid && wready_reg);
         if (s_axi_awvalid && awready_reg)
         begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_reg)
         begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_en)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? `ASC_RESP_OK : `ASC_RESP_ERR;
         end
         else if (bvalid_reg && s_axi_bready)
         begin
            bvalid_reg <= 1'b0;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= `ASC_RESP_OK;
      end
      else if (ar_hs)
      begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_val;
         rresp_reg <= rd_ok ? `ASC_RESP_OK : `ASC_RESP_ERR;
      end
      else if (rvalid_reg && s_axi_rready || !rvalid_reg)
      begin
         rvalid_reg <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   // ==========================================
   // Start sources
   wire idle = state_reg == ASC_IDLE;
   wire [1:0] mode = ctrl_reg[`ASC_CTL_MODE +: 2];
   wire trig_en = ctrl_reg[`ASC_CTL_TRIGEN];
   wire ext_sel = ctrl_reg[`ASC_CTL_EXT];
   wire ext_rise = ext_s2_reg && !ext_s3_reg;
   wire sw_go = wr_ctrl && wd[`ASC_CTL_ST] && w_strb_reg[0];
   wire link_ok_a = trig_en && !ext_sel && trs_reg[5:0] != `ASC_TRS_OFF;
   wire link_ok_b = trig_en && !ext_sel && trs_reg[`ASC_TRS_B +: 6] != `ASC_TRS_OFF;
   wire grp_mode = mode == ASC_GROUP;
   wire go_b = grp_mode && link_ok_b && link_event_conv_b && !(link_ok_a && link_event_conv_a);
   wire go_a = sw_go || link_ok_a && link_event_conv_a || trig_en && ext_sel && ext_rise && !grp_mode;
   wire [21:0] sel_a = {sel1_reg, sel0_reg};
   wire [21:0] sel_go = go_b ? selb_reg : sel_a;
   wire start = idle && (go_a || go_b) && sel_go != 22'h0;

   // ==========================================
   // Lowest pending channel first
   logic [4:0] low_ch;
   always_comb
   begin
      low_ch = 5'h00;
      for (int i = `ASC_NCH - 1; i >= 0; i--)
      begin
         if (pend_reg[i])
         begin
            low_ch = 5'(i);
         end
      end
   end

   wire conv_end = state_reg == ASC_CONV && cnt_reg == 8'h00;
   wire [21:0] pend_left = pend_reg & ~(22'h1 << chan_reg);
   wire scan_done = conv_end && pend_left == 22'h0;
   wire cont_go = mode == ASC_CONT && ctrl_reg[`ASC_CTL_ST] && !(wr_ctrl && !ctrl_w[`ASC_CTL_ST]);
   wire [7:0] conv_cyc = ctrl_reg[`ASC_CTL_LP] ? 8'(`ASC_CONV_LP_CYC - 1) : 8'(`ASC_CONV_HS_CYC - 1);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= ASC_IDLE;
         pend_reg <= 22'h0;
         cnt_reg <= 8'h00;
         chan_reg <= 5'h00;
         grp_b_reg <= 1'b0;
         sample_reg <= 1'b0;
      end
      else
      begin
         sample_reg <= 1'b0;
         case (state_reg)
            ASC_IDLE:
            begin
               if (start)
               begin
                  pend_reg <= sel_go;
                  grp_b_reg <= go_b;
                  state_reg <= ASC_PICK;
               end
            end
            ASC_PICK:
            begin
               chan_reg <= low_ch;
               cnt_reg <= conv_cyc;
               sample_reg <= 1'b1;
               state_reg <= ASC_CONV;
            end
            ASC_CONV:
            begin
               if (conv_end)
               begin
                  pend_reg <= pend_left;
                  if (pend_left != 22'h0)
                  begin
                     state_reg <= ASC_PICK;
                  end
                  else if (cont_go)
                  begin
                     pend_reg <= grp_b_reg ? selb_reg : sel_a;
                     state_reg <= ASC_PICK;
                  end
                  else
                  begin
                     state_reg <= ASC_IDLE;
                  end
               end
               else
               begin
                  cnt_reg <= cnt_reg - 8'h01;
               end
            end
            default:
            begin
               state_reg <= ASC_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // Control register; scan start bit set by start, cleared on single/group end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_reg <= 10'h000;
      end
      else
      begin
         if (wr_ctrl)
         begin
            ctrl_reg[8:0] <= ctrl_w[8:0];
         end
         if (start)
         begin
            ctrl_reg[`ASC_CTL_ST] <= 1'b1;
         end
         else if (scan_done && !cont_go)
         begin
            ctrl_reg[`ASC_CTL_ST] <= 1'b0;
         end
         else if (idle && wr_ctrl)
         begin
            ctrl_reg[`ASC_CTL_ST] <= 1'b0;
         end
         ctrl_reg[`ASC_CTL_BUSY] <= !(idle && !start) && !(scan_done && !cont_go);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sel0_reg <= 16'h0;
         sel1_reg <= 6'h0;
         selb_reg <= 22'h0;
         trs_reg <= {`ASC_TRS_OFF, 2'h0, `ASC_TRS_OFF};
         cmpc_reg <= 3'h0;
         cmps_reg <= 22'h0;
         cmpl_reg <= 22'h0;
         ref0_reg <= 12'h0;
         ref1_reg <= 12'h0;
         mask_reg <= 3'h0;
      end
      else
      begin
         if (wr_sel0) sel0_reg <= wd[15:0];
         if (wr_sel1) sel1_reg <= wd[5:0];
         if (wr_selb) selb_reg <= wd[21:0];
         if (wr_trs) trs_reg <= {wd[13:8], 2'h0, wd[5:0]};
         if (wr_cmpc) cmpc_reg <= wd[2:0];
         if (wr_cmps) cmps_reg <= wd[21:0];
         if (wr_cmpl) cmpl_reg <= wd[21:0];
         if (wr_ref0) ref0_reg <= wd[11:0];
         if (wr_ref1) ref1_reg <= wd[11:0];
         if (wr_mask) mask_reg <= wd[2:0];
      end
   end

   // ==========================================
   // Window compare on the sample as it lands
   wire cond = cmpl_reg[chan_reg];
   wire in_win = ref0_reg < sar_result && sar_result < ref1_reg;
   wire out_win = sar_result < ref0_reg || ref1_reg < sar_result;
   wire met = cmpc_reg[`ASC_CMP_WIN] ? (cond ? in_win : out_win)
      : (cond ? ref0_reg < sar_result : ref0_reg > sar_result);
   wire cmp_ok = conv_end && cmpc_reg[`ASC_CMP_AE] && cmps_reg[chan_reg];
   wire [2:0] st_set = {cmp_ok && !met, cmp_ok && met && cmpc_reg[`ASC_CMP_AIE], scan_done};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         match_reg <= 1'b0;
         miss_reg <= 1'b0;
         stat_reg <= 3'h0;
         irq_reg <= 1'b0;
         ext_s1_reg <= 1'b0;
         ext_s2_reg <= 1'b0;
         ext_s3_reg <= 1'b0;
      end
      else
      begin
         match_reg <= cmp_ok && met;
         miss_reg <= cmp_ok && !met;
         // Set beats a write-one-to-clear in the same cycle
         stat_reg <= (stat_reg & ~(wr_stat ? wd[2:0] : 3'h0)) | st_set;
         irq_reg <= |(stat_reg & mask_reg);
         ext_s1_reg <= external_trigger_pin;
         ext_s2_reg <= ext_s1_reg;
         ext_s3_reg <= ext_s2_reg;
      end
   end

   // ==========================================
   // Per-channel results; a landing sample wins over a clearing read
   genvar g;
   generate
      for (g = 0; g < `ASC_NCH; g++)
      begin : g_res
         wire land = conv_end && chan_reg == 5'(g);
         wire rclr = ar_hs && rd_res && rd_idx == 5'(g) && ctrl_reg[`ASC_CTL_AUTOCLR];
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               res_reg[g] <= 12'h000;
            else if (land)
               res_reg[g] <= sar_result;
            else if (rclr)
               res_reg[g] <= 12'h000;
         end
      end
   endgenerate

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign sar_chan = chan_reg;
   assign sar_sample = sample_reg;
   assign sar_low_power = ctrl_reg[`ASC_CTL_LP];
   assign scan_busy = ctrl_reg[`ASC_CTL_BUSY];
   assign compare_match_event = match_reg;
   assign compare_mismatch_event = miss_reg;
   assign irq = irq_reg;

   // ==========================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire [21:0] below = (22'h1 << chan_reg) - 22'h1;

   a_event_exclusive: assert property (!(match_reg && miss_reg))
      else $error("match and mismatch together");
   a_one_event: assert property (cmp_ok |=> (match_reg ^ miss_reg))
      else $error("compared conversion gave no single event");
   a_no_event: assert property (conv_end && !cmp_ok |=> !match_reg && !miss_reg)
      else $error("event without comparison");
   a_lowest_first: assert property (sample_reg |-> pend_reg[chan_reg] && (pend_reg & below) == 22'h0)
      else $error("channel order not ascending");
   a_result_land: assert property (conv_end && chan_reg == 5'h00 |=> res_reg[0] == $past(sar_result))
      else $error("result not stored in its channel");
   a_single_stop: assert property (scan_done && mode == ASC_SINGLE |=> idle && !ctrl_reg[`ASC_CTL_ST])
      else $error("single scan did not stop");
   a_cont_repeat: assert property (scan_done && cont_go |=> state_reg == ASC_PICK ##1 sample_reg)
      else $error("continuous scan did not repeat");
   a_busy_ignore: assert property (state_reg == ASC_CONV && !conv_end |=> $stable(pend_reg))
      else $error("trigger disturbed a running scan");
   a_conv_length: assert property (sample_reg && !sar_low_power |-> cnt_reg == 8'(`ASC_CONV_HS_CYC - 1))
      else $error("high-speed conversion length wrong");
   a_auto_clear: assert property (ar_hs && rd_res && rd_idx == 5'h00 && ctrl_reg[`ASC_CTL_AUTOCLR]
      && !(conv_end && chan_reg == 5'h00) |=> res_reg[0] == 12'h000)
      else $error("auto clear missed");
endmodule // asc_top

// ---- verification/asc_sar_model.sv ----
`timescale 1ns/10ps
`include "asc_params.svh"
module asc_sar_model
(
   input wire logic aclk,
   input wire logic [4:0] sar_chan,
   input wire logic sar_sample,
   input wire logic sar_low_power,
   output logic [11:0] sar_result
);
   // ==========================================
   // Conversion window
   int cnt_reg = 0;
   logic [11:0] last_reg = 12'h5a5;
   // Outside a conversion the line flips each cycle, so a late sample cannot look right
   assign sar_result = (cnt_reg > 0) ? {sar_chan, 7'h15} : ~last_reg;
   always_ff @(posedge aclk)
   begin
      if (sar_sample) cnt_reg <= sar_low_power ? `ASC_CONV_LP_CYC : `ASC_CONV_HS_CYC;
      else if (cnt_reg > 0) cnt_reg <= cnt_reg - 1;
      last_reg <= sar_result;
   end
endmodule // asc_sar_model

// ---- verification/asc_top_bench.sv ----
`timescale 1ns/10ps
`include "asc_params.svh"
module asc_top_bench;
   // ==========================================
   // Signals
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic external_trigger_pin = 1'b0;
   logic link_event_conv_a = 1'b0;
   logic link_event_conv_b = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [11:0] sar_result;
   logic [4:0] sar_chan;
   logic sar_sample, sar_low_power, scan_busy, compare_match_event, compare_mismatch_event, irq;
   int miscompares = 0;
   int n_tests = 0;
   int cyc = 0;
   int n_match = 0;
   int n_miss = 0;
   int hs_gap = 0;
   logic [4:0] chans[$];
   int stamps[$];
   logic [31:0] rv;
   logic [1:0] rr;
   asc_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sar_result(sar_result),
      .external_trigger_pin(external_trigger_pin), .link_event_conv_a(link_event_conv_a),
      .link_event_conv_b(link_event_conv_b), .sar_chan(sar_chan), .sar_sample(sar_sample),
      .sar_low_power(sar_low_power), .scan_busy(scan_busy), .compare_match_event(compare_match_event),
      .compare_mismatch_event(compare_mismatch_event), .irq(irq));
   asc_sar_model sar (.aclk(aclk), .sar_chan(sar_chan), .sar_sample(sar_sample),
      .sar_low_power(sar_low_power), .sar_result(sar_result));
   initial forever #5 aclk = ~aclk;
   // ==========================================
   // Monitors: outputs are flops, so the falling edge sees them settled
   always @(negedge aclk)
   begin
      cyc++;
      if (aresetn && sar_sample)
      begin
         chans.push_back(sar_chan);
         stamps.push_back(cyc);
      end
      if (aresetn && compare_match_event) n_match++;
      if (aresetn && compare_mismatch_event) n_miss++;
   end
   // ==========================================
   // Bus tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, hb;
      aw = 1'b1;
      w = 1'b1;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(negedge aclk);
         hb = !aw && !w && s_axi_bvalid;
         rr = s_axi_bresp;
         if (s_axi_awready) aw = 1'b0;
         if (s_axi_wready) w = 1'b0;
         @(posedge aclk);
         if (!aw) s_axi_awvalid <= 1'b0;
         if (!w) s_axi_wvalid <= 1'b0;
      end while (!hb);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      logic ar, hr;
      ar = 1'b1;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(negedge aclk);
         hr = !ar && s_axi_rvalid;
         rv = s_axi_rdata;
         rr = s_axi_rresp;
         if (s_axi_arready) ar = 1'b0;
         @(posedge aclk);
         if (!ar) s_axi_arvalid <= 1'b0;
      end while (!hr);
      s_axi_rready <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(rv, e);
   endtask
   task automatic ws(input int n);
      while (chans.size() < n || scan_busy !== 1'b0) @(negedge aclk);
      repeat (5) @(negedge aclk);
   endtask
   task automatic go(input logic [31:0] s0, input logic [31:0] c);
      wr(`ASC_OFF_SEL0, s0);
      chans.delete();
      stamps.delete();
      n_match = 0;
      n_miss = 0;
      wr(`ASC_OFF_CTRL, c);
   endtask
   task automatic pulse(input logic b);
      @(posedge aclk);
      if (b) link_event_conv_b <= 1'b1;
      else link_event_conv_a <= 1'b1;
      @(posedge aclk);
      link_event_conv_a <= 1'b0;
      link_event_conv_b <= 1'b0;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_regs;
      rc(`ASC_OFF_CTRL, 32'h0);
      chk(rr, 2'b00);
      rc(`ASC_OFF_TRS, 32'h3f3f);
      rd(8'h30);
      chk(rr, 2'b10);
      wr(8'h30, 32'h1);
      chk(rr, 2'b10);
      wr(`ASC_OFF_CMPC, 32'h0);
      chk(rr, 2'b00);
   endtask
   task automatic t_single;
      wr(`ASC_OFF_SEL1, 32'h20);
      go(32'ha, 32'h1);
      repeat (20) @(negedge aclk);
      wr(`ASC_OFF_CTRL, 32'h1);
      ws(3);
      chk({chans[0], chans[1], chans[2]}, {5'd1, 5'd3, 5'd21});
      hs_gap = stamps[1] - stamps[0];
      chk(hs_gap, `ASC_CONV_HS_CYC + 1);
      rc(`ASC_OFF_RES + 8'd4, 32'h095);
      rc(`ASC_OFF_RES + 8'd4, 32'h095);
      rc(`ASC_OFF_RES + 8'd84, 32'ha95);
      rc(`ASC_OFF_CTRL, 32'h0);
      repeat (300) @(negedge aclk);
      chk(chans.size(), 3);
   endtask
   task automatic t_clear;
      go(32'ha, 32'h101);
      ws(3);
      rc(`ASC_OFF_RES + 8'd12, 32'h195);
      rc(`ASC_OFF_RES + 8'd12, 32'h0);
   endtask
   task automatic t_lowpow;
      go(32'ha, 32'h9);
      ws(3);
      chk(sar_low_power, 1'b1);
      chk(stamps[1] - stamps[0] - hs_gap, `ASC_CONV_LP_CYC - `ASC_CONV_HS_CYC);
      wr(`ASC_OFF_SEL1, 32'h0);
   endtask
   task automatic t_compare;
      int i;
      wr(`ASC_OFF_CMPS, 32'h8);
      wr(`ASC_OFF_REF0, 32'h100);
      wr(`ASC_OFF_REF1, 32'h200);
      wr(`ASC_OFF_MASK, 32'h2);
      for (i = 0; i < 4; i++)
      begin
         wr(`ASC_OFF_STAT, 32'h7);
         wr(`ASC_OFF_CMPL, i[0] ? 32'h8 : 32'h0);
         wr(`ASC_OFF_CMPC, 32'h6 | i[1]);
         go(32'ha, 32'h1);
         ws(2);
         chk(n_match + 2 * n_miss, i[0] ? 1 : 2);
         chk(irq, i[0]);
      end
      wr(`ASC_OFF_MASK, 32'h0);
      repeat (3) @(negedge aclk);
      chk(irq, 1'b0);
      wr(`ASC_OFF_MASK, 32'h2);
      repeat (3) @(negedge aclk);
      chk(irq, 1'b1);
      wr(`ASC_OFF_STAT, 32'h2);
      repeat (3) @(negedge aclk);
      chk(irq, 1'b0);
   endtask
   task automatic t_cont;
      int n;
      go(32'h2, 32'h5);
      while (chans.size() < 3) @(negedge aclk);
      chk(scan_busy, 1'b1);
      wr(`ASC_OFF_CTRL, 32'h4);
      while (scan_busy !== 1'b0) @(negedge aclk);
      n = chans.size();
      repeat (400) @(negedge aclk);
      chk(chans.size(), n);
   endtask
   task automatic t_group;
      wr(`ASC_OFF_SELB, 32'h20);
      wr(`ASC_OFF_TRS, 32'h100);
      go(32'ha, 32'h12);
      pulse(1'b1);
      ws(1);
      pulse(1'b0);
      repeat (20) @(negedge aclk);
      pulse(1'b0);
      ws(3);
      repeat (300) @(negedge aclk);
      chk(chans.size(), 3);
      chk({chans[0], chans[1], chans[2]}, {5'd5, 5'd1, 5'd3});
      wr(`ASC_OFF_TRS, 32'h13f);
      pulse(1'b0);
      repeat (300) @(negedge aclk);
      chk(chans.size(), 3);
   endtask
   task automatic t_ext;
      go(32'ha, 32'h30);
      @(posedge aclk);
      external_trigger_pin <= 1'b1;
      ws(2);
      chk({chans[0], chans[1]}, {5'd1, 5'd3});
      @(posedge aclk);
      external_trigger_pin <= 1'b0;
   endtask
   // ==========================================
   // Run
   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
      begin
         $display("[ PASS ]");
      end
      else
      begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // About five thousand cycles expected; ten times that means a hang
   initial
   begin
      #500000;
      miscompares++;
      summarize();
   end
   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_regs();
      t_single();
      t_clear();
      t_lowpow();
      t_compare();
      t_cont();
      t_group();
      t_ext();
      summarize();
   end
endmodule // asc_top_bench
